// *** coaa_pkg.sv ***
// Package: offsets, encodings and carriers of the operand and arithmetic block
package coaa_pkg;
    // Register port offsets (word index)
    localparam logic [5:0] OFF_WREG0 = 6'h00;
    localparam logic [5:0] OFF_STATUS = 6'h10;
    localparam logic [5:0] OFF_OPERAND = 6'h11;
    localparam logic [5:0] OFF_CMD = 6'h12;
    localparam logic [5:0] OFF_ACCA_LO = 6'h13;
    localparam logic [5:0] OFF_ACCA_HI = 6'h14;
    localparam logic [5:0] OFF_ACCB_LO = 6'h15;
    localparam logic [5:0] OFF_ACCB_HI = 6'h16;
    localparam logic [5:0] OFF_FADDR = 6'h17;
    localparam logic [5:0] OFF_FDATA = 6'h18;
    // Fixed working register roles, byte literal limit, status reset value and accumulator limits
    localparam logic [3:0] DEFAULT_WORK_ALIAS = 4'h0;
    localparam logic [3:0] XPTR_LO = 4'h8;
    localparam logic [3:0] YPTR_LO = 4'ha;
    localparam logic [3:0] INDEX_REG = 4'hc;
    localparam logic [1:0] FETCH_DEST_BASE = 2'h1;
    localparam logic [9:0] LIT_BYTE_MAX = 10'h0ff;
    localparam logic [9:0] STATUS_RST = 10'h000;
    localparam logic [39:0] ACC_MAX = 40'h7fffffffff;
    localparam logic [39:0] ACC_MIN = 40'h8000000000;
    // Operation families (upper op bits) and forms (lower op bits)
    localparam logic [2:0] FAM_ADD = 3'h0;
    localparam logic [2:0] FAM_SUMC = 3'h1;
    localparam logic [2:0] FAM_AND = 3'h2;
    localparam logic [2:0] FAM_SRS = 3'h3;
    localparam logic [2:0] FAM_MISC = 3'h4;
    localparam logic [2:0] FAM_MUL = 3'h5;

    typedef enum logic [5:0] {
        OP_ADD_F = 6'h00, OP_ADD_FW = 6'h01, OP_ADD_LIT = 6'h02, OP_ADD_WWW = 6'h03, OP_ADD_WL5 = 6'h04,
        OP_SUM_CARRY_F = 6'h08, OP_SUM_CARRY_FW = 6'h09, OP_SUM_CARRY_LIT = 6'h0a,
        OP_SUM_CARRY_WWW = 6'h0b, OP_SUM_CARRY_WL5 = 6'h0c,
        OP_AND_F = 6'h10, OP_AND_FW = 6'h11, OP_AND_LIT = 6'h12, OP_AND_WWW = 6'h13, OP_AND_WL5 = 6'h14,
        OP_SRS_F = 6'h18, OP_SRS_FW = 6'h19, OP_SRS_WW = 6'h1a, OP_SRS_WNS = 6'h1b, OP_SRS_WL5 = 6'h1c,
        OP_ADD_ACC = 6'h20, OP_ADD_SACC = 6'h21, OP_BIT_ZERO_F = 6'h22,
        OP_MUL_SQR = 6'h28, OP_MUL_PAIR = 6'h29
    } coaa_op_t;

    typedef struct packed {
        logic [4:0] pad;
        coaa_op_t op;
        logic byte_mode;
        logic acc_b;
        logic [3:0] small_signed_shift;
        logic [2:0] mul_pair;
        logic [3:0] xspace_fetch_pointer;
        logic [1:0] xd;
        logic [3:0] yspace_fetch_pointer;
        logic [1:0] yd;
    } coaa_cmd_t;

    typedef struct packed {
        logic [9:0] pad;
        logic [3:0] base_work_reg;
        logic [3:0] ws;
        logic [3:0] wd;
        logic [9:0] ten_bit_literal;
    } coaa_opr_t;

    typedef struct packed {
        logic refused;
        logic acc_b_saturate_flag;
        logic acc_a_saturate_flag;
        logic acc_b_overflow_flag;
        logic acc_a_overflow_flag;
        logic zero_flag;
        logic signed_overflow_flag;
        logic neg_flag;
        logic half_carry_flag;
        logic carry_flag;
    } coaa_flags_t;

    typedef struct packed {
        logic [15:0] res;
        logic c;
        logic dc;
        logic n;
        logic ov;
    } coaa_alu_t;

    typedef struct packed {
        logic en;
        logic wr_ptr;
        logic [15:0] ptr_new;
        logic [15:0] addr;
    } coaa_fetch_t;
endpackage

// *** coaa_core.sv ***
// Operand check, prefetch and first arithmetic instructions of the core
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module coaa_core #(
    parameter int FILE_WORDS = 64,
    parameter int FA_W = $clog2(FILE_WORDS)
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_q,
    // Execution status
    output logic op_done_q,
    output logic op_refused_q
);

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic [15:0] w_q [16];
    logic [15:0] mem_q [FILE_WORDS];
    logic [39:0] acc_a_q;
    logic [39:0] acc_b_q;
    coaa_pkg::coaa_flags_t flags_q;
    coaa_pkg::coaa_cmd_t cmd_q;
    coaa_pkg::coaa_opr_t opr_q;
    logic [FA_W-1:0] faddr_q;
    logic go_q;

    ////////////////////////////////////////////////////////////////
    function automatic coaa_pkg::coaa_alu_t add_f(input logic [15:0] a, input logic [15:0] b,
                                                  input logic ci, input logic bm);
        logic [16:0] s;
        logic [8:0] s8;
        logic [4:0] h;
        coaa_pkg::coaa_alu_t r;
        s = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
        s8 = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        r.res = s[15:0];
        r.c = bm ? s8[8] : s[16];
        r.dc = bm ? h[4] : s8[8];
        r.n = bm ? s8[7] : s[15];
        r.ov = bm ? (a[7] == b[7]) && (s8[7] != a[7]) : (a[15] == b[15]) && (s[15] != a[15]);
        return r;
    endfunction

    function automatic logic is_zero(input logic [15:0] v, input logic bm);
        return bm ? (v[7:0] == 8'h00) : (v == 16'h0000);
    endfunction

    // Guard bits disagreeing with bit 31 mark accumulator overflow
    function automatic logic guard_ovf(input logic [39:0] v);
        return !((&v[39:31]) || !(|v[39:31]));
    endfunction

    // Decodes multiplier registers; bit 4 is legality
    function automatic logic [4:0] mul_sel(input logic sq, input logic [2:0] code);
        logic [4:0] r;
        r = 5'h00;
        if (sq) begin
            r = {!code[2], code[1:0], code[1:0]};
        end else begin
            case (code)
                3'h0: r = 5'h11;
                3'h1: r = 5'h12;
                3'h2: r = 5'h13;
                3'h3: r = 5'h16;
                3'h4: r = 5'h17;
                3'h5: r = 5'h1b;
                default: r = 5'h00;
            endcase
        end
        return r;
    endfunction

    // Prefetch pointer decode, shared by the X and Y paths
    function automatic coaa_pkg::coaa_fetch_t fetch_f(input logic [3:0] code, input logic [15:0] lo,
                                                      input logic [15:0] hi, input logic [15:0] idx);
        coaa_pkg::coaa_fetch_t f;
        logic [15:0] p;
        p = code[3] ? hi : lo;
        f.en = 1'b1;
        f.wr_ptr = 1'b1;
        f.addr = p;
        case (code[2:0])
            3'h0: begin
                f.en = code[3];
                f.wr_ptr = 1'b0;
                f.addr = p + idx;
            end
            3'h1: f.wr_ptr = 1'b0;
            3'h2: f.ptr_new = p + 16'h0002;
            3'h3: f.ptr_new = p + 16'h0004;
            3'h4: f.ptr_new = p + 16'h0006;
            3'h5: f.ptr_new = p - 16'h0002;
            3'h6: f.ptr_new = p - 16'h0004;
            default: f.ptr_new = p - 16'h0006;
        endcase
        if (code[2:0] < 3'h2) begin
            f.ptr_new = p;
        end
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Execution datapath
    logic [2:0] fam;
    logic [2:0] form;
    logic bm;
    logic [15:0] fval, w0_v, wb_v, ws_v, wd_v, a, b, r_res, x_data, y_data, wm_v, wn_v;
    logic [4:0] five_bit_literal;
    logic legal, dst_file, dst_w, acc_we, mul_op;
    logic [3:0] r_wi;
    logic [4:0] msel;
    logic [40:0] acc_sum;
    logic [39:0] acc_sel, acc_in, acc_res;
    logic [31:0] prod;
    coaa_pkg::coaa_alu_t alu;
    coaa_pkg::coaa_flags_t fl;
    coaa_pkg::coaa_fetch_t xf, yf;

    always_comb begin
        fam = cmd_q.op[5:3];
        form = cmd_q.op[2:0];
        bm = cmd_q.byte_mode;
        fval = mem_q[opr_q.ten_bit_literal[FA_W-1:0]];
        w0_v = w_q[coaa_pkg::DEFAULT_WORK_ALIAS];
        wb_v = w_q[opr_q.base_work_reg];
        ws_v = w_q[opr_q.ws];
        wd_v = w_q[opr_q.wd];
        five_bit_literal = opr_q.ten_bit_literal[4:0];
        a = 16'h0000;
        b = 16'h0000;
        r_res = 16'h0000;
        alu = '0;
        fl = flags_q;
        legal = 1'b1;
        dst_file = 1'b0;
        dst_w = 1'b0;
        r_wi = opr_q.wd;
        acc_we = 1'b0;
        mul_op = 1'b0;
        acc_sel = cmd_q.acc_b ? acc_b_q : acc_a_q;
        acc_in = 40'h0;
        acc_sum = 41'h0;
        acc_res = 40'h0;
        msel = mul_sel(form == 3'h0, cmd_q.mul_pair);
        wm_v = w_q[{2'h1, msel[3:2]}];
        wn_v = w_q[{2'h1, msel[1:0]}];
        prod = 32'($signed(wm_v) * $signed(wn_v));
        xf = fetch_f(cmd_q.xspace_fetch_pointer, w_q[coaa_pkg::XPTR_LO], w_q[coaa_pkg::XPTR_LO + 4'h1],
                     w_q[coaa_pkg::INDEX_REG]);
        yf = fetch_f(cmd_q.yspace_fetch_pointer, w_q[coaa_pkg::YPTR_LO], w_q[coaa_pkg::YPTR_LO + 4'h1],
                     w_q[coaa_pkg::INDEX_REG]);
        x_data = mem_q[xf.addr[FA_W:1]];
        y_data = mem_q[yf.addr[FA_W:1]];
        // Operand forms shared by add, add-with-carry, and, shift
        case (form)
            3'h0, 3'h1: begin
                a = fval;
                b = w0_v;
                dst_file = (form == 3'h0);
                dst_w = (form == 3'h1);
                r_wi = coaa_pkg::DEFAULT_WORK_ALIAS;
            end
            3'h2: begin
                a = wd_v;
                b = {6'h00, opr_q.ten_bit_literal};
                dst_w = 1'b1;
                legal = !(bm && opr_q.ten_bit_literal > coaa_pkg::LIT_BYTE_MAX);
            end
            3'h3: begin
                a = wb_v;
                b = ws_v;
                dst_w = 1'b1;
            end
            3'h4: begin
                a = wb_v;
                b = {11'h000, five_bit_literal};
                dst_w = 1'b1;
            end
            default: legal = 1'b0;
        endcase
        case (fam)
            coaa_pkg::FAM_ADD, coaa_pkg::FAM_SUMC: begin
                alu = add_f(a, b, (fam == coaa_pkg::FAM_SUMC) && flags_q.carry_flag, bm);
                r_res = alu.res;
                fl.carry_flag = alu.c;
                fl.half_carry_flag = alu.dc;
                fl.neg_flag = alu.n;
                fl.signed_overflow_flag = alu.ov;
                // Zero only clears across multi-precision chains
                fl.zero_flag = is_zero(r_res, bm) && (fam == coaa_pkg::FAM_ADD || flags_q.zero_flag);
            end
            coaa_pkg::FAM_AND: begin
                r_res = a & b;
                fl.neg_flag = bm ? r_res[7] : r_res[15];
                fl.zero_flag = is_zero(r_res, bm);
            end
            coaa_pkg::FAM_SRS: begin
                if (form == 3'h3 || form == 3'h4) begin
                    r_res = 16'($signed(wb_v) >>> (form == 3'h3 ? ws_v[4:0] : five_bit_literal));
                    r_wi = opr_q.wd;
                    fl.neg_flag = r_res[15];
                    fl.zero_flag = (r_res == 16'h0000);
                end else begin
                    if (form == 3'h2) begin
                        a = ws_v;
                        // No literal in this form, so the byte literal limit does not apply
                        legal = 1'b1;
                    end
                    r_res = bm ? {a[15:8], a[7], a[7:1]} : {a[15], a[15:1]};
                    fl.carry_flag = a[0];
                    fl.neg_flag = bm ? r_res[7] : r_res[15];
                    fl.signed_overflow_flag = 1'b0;
                    fl.zero_flag = is_zero(r_res, bm);
                end
            end
            coaa_pkg::FAM_MISC: begin
                dst_w = 1'b0;
                dst_file = 1'b0;
                legal = 1'b1;
                if (form == 3'h2) begin
                    r_res = fval & ~(16'h0001 << opr_q.base_work_reg);
                    dst_file = 1'b1;
                end else if (form < 3'h2) begin
                    acc_we = 1'b1;
                    if (form == 3'h0) begin
                        acc_in = cmd_q.acc_b ? acc_a_q : acc_b_q;
                    end else if (cmd_q.small_signed_shift[3]) begin
                        acc_in = {{8{ws_v[15]}}, ws_v, 16'h0000} << (5'h10 - {1'b0, cmd_q.small_signed_shift});
                    end else begin
                        acc_in = 40'($signed({{8{ws_v[15]}}, ws_v, 16'h0000}) >>> cmd_q.small_signed_shift);
                    end
                    acc_sum = {acc_sel[39], acc_sel} + {acc_in[39], acc_in};
                    acc_res = acc_sum[39:0];
                    // Saturate rather than wrap on a 40-bit overflow
                    if (acc_sum[40] != acc_sum[39]) begin
                        acc_res = acc_sum[40] ? coaa_pkg::ACC_MIN : coaa_pkg::ACC_MAX;
                    end
                    if (cmd_q.acc_b) begin
                        fl.acc_b_overflow_flag = guard_ovf(acc_res);
                        fl.acc_b_saturate_flag = flags_q.acc_b_saturate_flag || (acc_sum[40] != acc_sum[39]);
                    end else begin
                        fl.acc_a_overflow_flag = guard_ovf(acc_res);
                        fl.acc_a_saturate_flag = flags_q.acc_a_saturate_flag || (acc_sum[40] != acc_sum[39]);
                    end
                end else begin
                    legal = 1'b0;
                end
            end
            coaa_pkg::FAM_MUL: begin
                dst_w = 1'b0;
                // Square form shares code 0 with the file form; never write the file
                dst_file = 1'b0;
                legal = msel[4] && form < 3'h2;
                mul_op = legal;
                acc_we = legal;
                acc_res = {{8{prod[31]}}, prod};
            end
            default: legal = 1'b0;
        endcase
        // Byte mode leaves the destination's upper byte alone, except in shift forms 3 and 4 and the bit-zero form, which write all 16 bits
        if (bm && (fam <= coaa_pkg::FAM_AND || (fam == coaa_pkg::FAM_SRS && form < 3'h3))) begin
            r_res = {dst_file ? fval[15:8] : w_q[r_wi][15:8], r_res[7:0]};
        end
        fl.refused = flags_q.refused || !legal;
    end

    ////////////////////////////////////////////////////////////////
    // Working registers: execution overrides a same-cycle port write
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < 16; i++) begin
                w_q[i] <= 16'h0000;
            end
        end else begin
            if (reg_wr && reg_addr[5:4] == 2'h0) begin
                w_q[reg_addr[3:0]] <= reg_wdata[15:0];
            end
            if (go_q && legal && dst_w) begin
                w_q[r_wi] <= r_res;
            end
            if (go_q && mul_op) begin
                if (xf.wr_ptr) begin
                    w_q[coaa_pkg::XPTR_LO + {3'h0, cmd_q.xspace_fetch_pointer[3]}] <= xf.ptr_new;
                end
                if (yf.wr_ptr) begin
                    w_q[coaa_pkg::YPTR_LO + {3'h0, cmd_q.yspace_fetch_pointer[3]}] <= yf.ptr_new;
                end
                if (xf.en) begin
                    w_q[{coaa_pkg::FETCH_DEST_BASE, cmd_q.xd}] <= x_data;
                end
                if (yf.en) begin
                    w_q[{coaa_pkg::FETCH_DEST_BASE, cmd_q.yd}] <= y_data;
                end
            end
        end
    end

    // File registers
    always_ff @(posedge clock) begin
        if (reg_wr && reg_addr == coaa_pkg::OFF_FDATA) begin
            mem_q[faddr_q] <= reg_wdata[15:0];
        end
        if (go_q && legal && dst_file) begin
            mem_q[opr_q.ten_bit_literal[FA_W-1:0]] <= r_res;
        end
    end

    // Accumulators
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            acc_a_q <= 40'h0;
            acc_b_q <= 40'h0;
        end else if (go_q && legal && acc_we) begin
            if (cmd_q.acc_b) begin
                acc_b_q <= acc_res;
            end else begin
                acc_a_q <= acc_res;
            end
        end
    end

    // Status: execution wins over a same-cycle port write
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flags_q <= coaa_pkg::STATUS_RST;
        end else if (go_q) begin
            flags_q <= legal ? fl : coaa_pkg::coaa_flags_t'({1'b1, flags_q[8:0]});
        end else if (reg_wr && reg_addr == coaa_pkg::OFF_STATUS) begin
            flags_q <= reg_wdata[9:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Command, operand and port registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cmd_q <= '0;
            opr_q <= '0;
            faddr_q <= '0;
            go_q <= 1'b0;
            op_done_q <= 1'b0;
            op_refused_q <= 1'b0;
        end else begin
            go_q <= reg_wr && reg_addr == coaa_pkg::OFF_CMD;
            op_done_q <= go_q;
            op_refused_q <= go_q && !legal;
            if (reg_wr && reg_addr == coaa_pkg::OFF_CMD) begin
                cmd_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == coaa_pkg::OFF_OPERAND) begin
                opr_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == coaa_pkg::OFF_FADDR) begin
                faddr_q <= reg_wdata[FA_W-1:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata_q <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                coaa_pkg::OFF_STATUS: reg_rdata_q <= {22'h0, flags_q};
                coaa_pkg::OFF_OPERAND: reg_rdata_q <= opr_q;
                coaa_pkg::OFF_CMD: reg_rdata_q <= cmd_q;
                coaa_pkg::OFF_ACCA_LO: reg_rdata_q <= acc_a_q[31:0];
                coaa_pkg::OFF_ACCA_HI: reg_rdata_q <= {24'h0, acc_a_q[39:32]};
                coaa_pkg::OFF_ACCB_LO: reg_rdata_q <= acc_b_q[31:0];
                coaa_pkg::OFF_ACCB_HI: reg_rdata_q <= {24'h0, acc_b_q[39:32]};
                coaa_pkg::OFF_FADDR: reg_rdata_q <= 32'(faddr_q);
                coaa_pkg::OFF_FDATA: reg_rdata_q <= {16'h0, mem_q[faddr_q]};
                default: reg_rdata_q <= (reg_addr[5:4] == 2'h0) ? {16'h0, w_q[reg_addr[3:0]]} : 32'h0;
            endcase
        end else begin
            reg_rdata_q <= 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////
    a_square_refuse: assert property (go_q && cmd_q.op == coaa_pkg::OP_MUL_SQR && cmd_q.mul_pair[2]
        |=> flags_q.refused && op_refused_q && $stable(acc_a_q) && $stable(acc_b_q))
        else $error("Illegal square pair accepted");
    a_pair_refuse: assert property (go_q && cmd_q.op == coaa_pkg::OP_MUL_PAIR && cmd_q.mul_pair > 3'h5
        |=> op_refused_q && $stable(acc_a_q) && $stable(acc_b_q))
        else $error("Illegal multiply pair accepted");
    a_xptr_step: assert property (go_q && cmd_q.op == coaa_pkg::OP_MUL_SQR && cmd_q.mul_pair == 3'h0
        && cmd_q.xspace_fetch_pointer == 4'h2 |=> w_q[8] == $past(w_q[8]) + 16'h0002)
        else $error("X pointer not advanced by two");
    a_yptr_step: assert property (go_q && cmd_q.op == coaa_pkg::OP_MUL_SQR && cmd_q.mul_pair == 3'h1
        && cmd_q.yspace_fetch_pointer == 4'he |=> w_q[11] == $past(w_q[11]) - 16'h0004)
        else $error("Y pointer not stepped back by four");
    a_fetch_dest: assert property (go_q && mul_op && xf.en && !yf.en && cmd_q.xd == 2'h3
        |=> w_q[7] == $past(x_data))
        else $error("Prefetch data missing in destination");
    a_alias_write: assert property (go_q && cmd_q.op == coaa_pkg::OP_SRS_FW && !bm
        |=> w_q[0] == {$past(fval[15]), $past(fval[15:1])} && flags_q.carry_flag == $past(fval[0]))
        else $error("Shift result not in alias register");
    a_sacc_flags: assert property (go_q && cmd_q.op inside {coaa_pkg::OP_ADD_SACC, coaa_pkg::OP_ADD_ACC}
        |=> $stable(flags_q[4:0]))
        else $error("Accumulator add touched core flags");
    a_nz_only: assert property (go_q && cmd_q.op inside {coaa_pkg::OP_SRS_WNS, coaa_pkg::OP_SRS_WL5,
        coaa_pkg::OP_AND_WWW} |=> $stable(flags_q.carry_flag) && $stable(flags_q.signed_overflow_flag))
        else $error("Shift or and changed carry or overflow");
    a_byte_literal: assert property (go_q && bm && form == 3'h2 && fam <= coaa_pkg::FAM_AND
        && opr_q.ten_bit_literal > 10'h0ff |=> op_refused_q ##1 !op_refused_q)
        else $error("Byte literal above 255 accepted");
    a_sticky_zero: assert property (go_q && legal && cmd_q.op == coaa_pkg::OP_SUM_CARRY_WWW
        && !flags_q.zero_flag |=> !flags_q.zero_flag)
        else $error("Sticky zero set by add-with-carry");
endmodule

// *** tb.sv ***
// Self-checking bench of the operand and arithmetic block
`timescale 1ns/100ps
module tb;
    logic clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, op_done_q, op_refused_q;
    logic [5:0] reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata_q, rd_v;
    int err_count = 0, samples_checked = 0;
    coaa_pkg::coaa_cmd_t cmd;
    typedef struct packed {
        logic [5:0] op;
        logic [15:0] b, s, d;
        logic [9:0] lit, st, est;
        logic [15:0] res;
    } coaa_row_t;
    // Base W1, source W2, destination W3
    coaa_row_t rows [8] = '{
        '{6'h03, 16'h7fff, 16'h0001, 16'h0, 10'h0, 10'h000, 10'h00e, 16'h8000},
        '{6'h0b, 16'hffff, 16'h0000, 16'h0, 10'h0, 10'h011, 10'h013, 16'h0000},
        '{6'h13, 16'hf0f0, 16'h8f00, 16'h0, 10'h0, 10'h001, 10'h005, 16'h8000},
        '{6'h1b, 16'h8000, 16'h0004, 16'h0, 10'h0, 10'h00b, 10'h00f, 16'hf800},
        '{6'h1c, 16'h8001, 16'h0000, 16'h0, 10'h00f, 10'h010, 10'h004, 16'hffff},
        '{6'h04, 16'h0001, 16'h0000, 16'h0, 10'h01f, 10'h01f, 10'h000, 16'h0020},
        '{6'h0a, 16'h0100, 16'h0000, 16'h0100, 10'h3ff, 10'h011, 10'h002, 16'h0500},
        '{6'h1a, 16'h0000, 16'h8003, 16'h0, 10'h0, 10'h000, 10'h005, 16'hc001}};

    coaa_core i_dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .op_done_q(op_done_q),
        .op_refused_q(op_refused_q));

    always #50 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe edge
    task automatic chk(input logic [5:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata_q;
        samples_checked++;
        if (rd_v !== e) begin
            err_count++;
            $display("MISMATCH %0t at %h got %h exp %h", $time, a, rd_v, e);
        end
    endtask

    task automatic run(input logic r);
        int n;
        n = 0;
        wr(6'h12, cmd);
        while (op_done_q !== 1'b1 && n < 6) begin
            @(posedge clock);
            #1 n++;
        end
        samples_checked++;
        if (n == 6 || op_refused_q !== r) begin
            err_count++;
            $display("MISMATCH %0t done or refusal wrong", $time);
            if (n == 6) stop_test();
        end
    endtask

    task automatic stop_test;
        $display("Checked %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        chk(6'h10, 32'h0);
        wr(6'h3f, 32'hffff);
        chk(6'h3f, 32'h0);
        $display("Reset and unmapped test done");
        foreach (rows[i]) begin
            wr(6'h01, {16'h0, rows[i].b});
            wr(6'h02, {16'h0, rows[i].s});
            wr(6'h03, {16'h0, rows[i].d});
            wr(6'h10, {22'h0, rows[i].st});
            wr(6'h11, {10'h0, 12'h123, rows[i].lit});
            cmd = '0;
            cmd.op = coaa_pkg::coaa_op_t'(rows[i].op);
            run(1'b0);
            chk(6'h03, {16'h0, rows[i].res});
            chk(6'h10, {22'h0, rows[i].est});
            $display("Row %0d done", i);
        end
        wr(6'h17, 32'h5);
        wr(6'h18, 32'h1234);
        wr(6'h00, 32'h1);
        wr(6'h11, 32'h5);
        cmd.op = coaa_pkg::OP_ADD_F;
        run(1'b0);
        chk(6'h18, 32'h1235);
        cmd.op = coaa_pkg::OP_SRS_FW;
        run(1'b0);
        chk(6'h00, 32'h091a);
        chk(6'h18, 32'h1235);
        wr(6'h04, 32'h3);
        wr(6'h05, 32'hfffe);
        cmd.op = coaa_pkg::OP_MUL_PAIR;
        run(1'b0);
        chk(6'h13, 32'hfffffffa);
        chk(6'h14, 32'hff);
        wr(6'h10, 32'h0);
        cmd.mul_pair = 3'h6;
        run(1'b1);
        cmd.op = coaa_pkg::OP_MUL_SQR;
        cmd.mul_pair = 3'h4;
        run(1'b1);
        wr(6'h11, 32'h100);
        cmd.op = coaa_pkg::OP_ADD_LIT;
        cmd.byte_mode = 1'b1;
        run(1'b1);
        chk(6'h10, 32'h200);
        $display("File, multiply and refusal tests done");
        wr(6'h17, 32'h2);
        wr(6'h18, 32'haa);
        wr(6'h17, 32'h4);
        wr(6'h18, 32'h55);
        wr(6'h08, 32'h4);
        wr(6'h0b, 32'h8);
        wr(6'h11, 32'h2);
        cmd = '0;
        cmd.op = coaa_pkg::OP_MUL_SQR;
        cmd.xspace_fetch_pointer = 4'h2;
        cmd.xd = 2'h3;
        run(1'b0);
        chk(6'h13, 32'h9);
        chk(6'h08, 32'h6);
        chk(6'h07, 32'haa);
        cmd.xspace_fetch_pointer = 4'h0;
        cmd.mul_pair = 3'h1;
        cmd.yspace_fetch_pointer = 4'he;
        cmd.yd = 2'h2;
        run(1'b0);
        chk(6'h13, 32'h4);
        chk(6'h0b, 32'h4);
        chk(6'h06, 32'h55);
        $display("Prefetch test done");
        cmd = '0;
        cmd.op = coaa_pkg::OP_ADD_SACC;
        cmd.acc_b = 1'b1;
        run(1'b0);
        chk(6'h15, 32'h091a0000);
        chk(6'h16, 32'h0);
        cmd.op = coaa_pkg::OP_ADD_ACC;
        cmd.acc_b = 1'b0;
        run(1'b0);
        chk(6'h13, 32'h091a0004);
        chk(6'h10, 32'h200);
        cmd.op = coaa_pkg::OP_SUM_CARRY_FW;
        run(1'b0);
        chk(6'h00, 32'h09c4);
        cmd.op = coaa_pkg::OP_SRS_F;
        run(1'b0);
        wr(6'h17, 32'h2);
        chk(6'h18, 32'h55);
        $display("Accumulator and file test done");
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        chk(6'h13, 32'h0);
        chk(6'h08, 32'h0);
        chk(6'h10, 32'h0);
        $display("Mid-run reset test done");
        stop_test();
    end
endmodule
